/* design/uts_pkg.sv */
// Package for the transfer status FIFO: register offsets, fields, resets.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package uts_pkg;
    localparam logic [7:0]  UTS_OFF_STATUS   = 8'h00;
    localparam logic [7:0]  UTS_OFF_IRQ_FLAG = 8'h04;
    localparam logic [7:0]  UTS_OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0]  UTS_OFF_LEVEL    = 8'h0C;
    localparam int          UTS_ENDP_LSB     = 4;
    localparam int          UTS_DIR_BIT      = 3;
    localparam int          UTS_PPB_BIT      = 2;
    localparam int          UTS_DEPTH        = 4;
    localparam int          UTS_AW           = 2;
    localparam int          UTS_ENTRY_W      = 6;
    localparam int          UTS_IRQ_W        = 2;
    localparam int          UTS_IRQ_TRN      = 0;
    localparam int          UTS_IRQ_OVF      = 1;
    localparam logic [1:0]  UTS_MASK_RST     = 2'h0;
    localparam logic [1:0]  UTS_FLAG_RST     = 2'h0;
    localparam logic [1:0]  UTS_HTRANS_NSEQ  = 2'h2;
    localparam logic [2:0]  UTS_LEVEL_RST    = 3'h0;
endpackage

/* design/uts_entry_mem.sv */
// Small entry memory holding queued transfer status words.
// Assumes one write port and one registered read port on i_clk.
`timescale 1ns/1ns
module uts_entry_mem
    import uts_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    // Write port
    input  wire logic                   i_wr_en,
    input  wire logic [UTS_AW-1:0]      i_wr_addr,
    input  wire logic [UTS_ENTRY_W-1:0] i_wr_data,
    // Read port
    input  wire logic [UTS_AW-1:0]      i_rd_addr,
    output logic      [UTS_ENTRY_W-1:0] o_rd_data
);
    logic [UTS_ENTRY_W-1:0] mem_ff [UTS_DEPTH];

    always_ff @(posedge i_clk)
    begin
        if (i_wr_en)
        begin
            mem_ff[i_wr_addr] <= i_wr_data;
        end
    end

    // Read data are registered; a fresh write shows up one cycle later.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_data <= mem_ff[i_rd_addr];
        end
    end
endmodule

/* design/uts_status_fifo.sv */
// Transfer completion status FIFO with an AHB-Lite register slave.
// Assumes completion events are one-cycle pulses on i_clk from the engine.
`timescale 1ns/1ns
// Notes on behaviour
// - Status bits 7:4 show the endpoint number of the head entry.
// - Status bit 3 is one for a transmit and zero for a receive.
// - Status bit 2 is one for the odd bank and zero for the even bank.
// - Status bits 31:8 and 1:0 always read as zero.
// - Entries queue in a four-deep FIFO whose head is the status register.
// - Clearing the completion flag pops the head entry.
module uts_status_fifo
    import uts_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [7:0]  i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Transfer engine completion events
    input  wire logic        i_xfer_done,
    input  wire logic [3:0]  i_xfer_endpoint,
    input  wire logic        i_xfer_tx,
    input  wire logic        i_xfer_odd_bank,
    // Interrupt
    output logic             o_irq
);
    // Queue state, bus phase state and decoded strobes.
    logic [UTS_AW-1:0]      wr_ptr_ff;
    logic [UTS_AW-1:0]      rd_ptr_ff;
    logic [2:0]             level_ff;
    logic [UTS_IRQ_W-1:0]   flag_ff;
    logic [UTS_IRQ_W-1:0]   mask_ff;
    logic                   ph_wr_ff;
    logic                   ph_rd_ff;
    logic [7:0]             ph_addr_ff;
    logic [UTS_ENTRY_W-1:0] head_data;
    logic                   push;
    logic                   pop;
    logic                   full;
    logic                   ap_valid;
    logic                   trn_clr;
    logic [UTS_IRQ_W-1:0]   nxt_flag;
    logic [UTS_AW-1:0]      rd_addr;

    // Next slot of a circular queue pointer; it wraps after the last entry.
    function automatic logic [UTS_AW-1:0] ptr_inc
    (
        input logic [UTS_AW-1:0] ptr
    );
        return UTS_AW'(ptr + 1'b1);
    endfunction

    // High in the data phase of a write to the register at the given offset.
    function automatic logic reg_wr_hit
    (
        input logic       wr,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return wr && (addr == offset);
    endfunction

    // A completion that finds all four slots taken is dropped and only
    // raises the overflow flag; the queued entries are left untouched.
    assign full     = (level_ff == 3'(UTS_DEPTH));
    assign ap_valid = i_hsel && i_hready && (i_htrans == UTS_HTRANS_NSEQ);
    assign trn_clr  = reg_wr_hit(ph_wr_ff, ph_addr_ff, UTS_OFF_IRQ_FLAG)
                      && i_hwdata[UTS_IRQ_TRN];
    assign push     = i_xfer_done && !full;
    assign pop      = trn_clr && flag_ff[UTS_IRQ_TRN]
                      && (level_ff != 3'h0);
    // Read the next head early so the data are ready as the pointer moves.
    assign rd_addr  = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;

    // An entry packs endpoint, direction and bank in status field order.
    // A push into an empty queue reaches the head register two cycles
    // later, so a status read must wait for the completion flag first.
    uts_entry_mem uts_entry_mem_inst
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (push),
        .i_wr_addr (wr_ptr_ff),
        .i_wr_data ({i_xfer_endpoint, i_xfer_tx, i_xfer_odd_bank}),
        .i_rd_addr (rd_addr),
        .o_rd_data (head_data)
    );

    // FIFO pointers and fill level. A push and a pop in one cycle move both
    // pointers and leave the level unchanged.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff  <= UTS_LEVEL_RST;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop)
            begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            level_ff <= 3'(level_ff + {2'h0, push} - {2'h0, pop});
        end
    end

    // The completion flag reflects a non-empty FIFO; a new push wins over
    // a clear, and a clear with more entries queued leaves it set.
    always_comb
    begin
        nxt_flag = flag_ff;
        // Writing a one clears that flag bit; writing a zero leaves it.
        // An overflow stays set until software writes a one to its bit.
        if (reg_wr_hit(ph_wr_ff, ph_addr_ff, UTS_OFF_IRQ_FLAG))
        begin
            nxt_flag = flag_ff & ~i_hwdata[UTS_IRQ_W-1:0];
        end
        if (pop && (level_ff > 3'h1))
        begin
            nxt_flag[UTS_IRQ_TRN] = 1'b1;
        end
        if (i_xfer_done)
        begin
            nxt_flag[UTS_IRQ_TRN] = 1'b1;
        end
        if (i_xfer_done && full)
        begin
            nxt_flag[UTS_IRQ_OVF] = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            flag_ff <= UTS_FLAG_RST;
        end
        else
        begin
            flag_ff <= nxt_flag;
        end
    end

    // Mask register and interrupt output.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mask_ff <= UTS_MASK_RST;
        end
        else if (reg_wr_hit(ph_wr_ff, ph_addr_ff, UTS_OFF_IRQ_MASK))
        begin
            mask_ff <= i_hwdata[UTS_IRQ_W-1:0];
        end
    end

    // The interrupt is a plain level: any unmasked flag holds it high.
    assign o_irq = |(flag_ff & mask_ff);

    // Address phase capture; every access completes with no wait state.
    // The address is taken every cycle; the phase strobes qualify it.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ph_wr_ff   <= 1'b0;
            ph_rd_ff   <= 1'b0;
            ph_addr_ff <= '0;
        end
        else
        begin
            ph_wr_ff   <= ap_valid && i_hwrite;
            ph_rd_ff   <= ap_valid && !i_hwrite;
            ph_addr_ff <= i_haddr;
        end
    end

    // Every access finishes at once with an OKAY response.
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // Read data mux, combinational over registered state in the data phase.
    // Unmapped offsets read as zero, and a read of an empty queue shows a
    // stale or unwritten entry that software must ignore.
    always_comb
    begin
        o_hrdata = 32'h0000_0000;
        if (ph_rd_ff)
        begin
            case (ph_addr_ff)
                UTS_OFF_STATUS:
                begin
                    // Bits outside the three fields keep the zero above.
                    o_hrdata[UTS_ENDP_LSB+3:UTS_ENDP_LSB] =
                        head_data[5:2];
                    o_hrdata[UTS_DIR_BIT] = head_data[1];
                    o_hrdata[UTS_PPB_BIT] = head_data[0];
                end
                UTS_OFF_IRQ_FLAG: o_hrdata[UTS_IRQ_W-1:0] = flag_ff;
                UTS_OFF_IRQ_MASK: o_hrdata[UTS_IRQ_W-1:0] = mask_ff;
                UTS_OFF_LEVEL:    o_hrdata[2:0] = level_ff;
                default:          o_hrdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

/* tb/uts_xfer_engine.sv */
// Model of the USB transfer engine: one completed transfer a call.
// Assumes calls start just after a rising edge of i_clk.
`timescale 1ns/1ns
module uts_xfer_engine
(
    // Clock
    input  wire logic i_clk,
    // Completion events
    output logic       o_done,
    output logic [3:0] o_endpoint,
    output logic       o_tx,
    output logic       o_odd_bank
);
    initial {o_done, o_endpoint, o_tx, o_odd_bank} = 7'h00;
    task automatic fire(input logic [5:0] e, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_done <= 1'b1;
        {o_endpoint, o_tx, o_odd_bank} <= e;
        @(posedge i_clk);
        o_done <= 1'b0;
        // Fields mean nothing between events, so they show the inverse.
        {o_endpoint, o_tx, o_odd_bank} <= ~e;
    endtask
endmodule

/* tb/uts_status_fifo_chk.sv */
// Checker: tracks the queue depth from bus writes and completions.
// Assumes zero wait states and the register map of the package.
`timescale 1ns/1ns
module uts_status_fifo_chk
    import uts_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_hsel,
    input wire logic [7:0]  i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic [31:0] o_hrdata,
    input wire logic        i_xfer_done,
    input wire logic [3:0]  i_xfer_endpoint,
    input wire logic        i_xfer_tx,
    input wire logic        i_xfer_odd_bank
);
    logic       acc, dp_ff, wr_ff, hv_ff, pop, push, st;
    logic [7:0] ad_ff;
    logic [2:0] cnt_ff;
    logic [5:0] hd_ff;
    assign acc = i_hsel && i_htrans == UTS_HTRANS_NSEQ && !i_sys_rst;
    assign pop = wr_ff && ad_ff == UTS_OFF_IRQ_FLAG && i_hwdata[0]
                 && cnt_ff != 3'h0;
    assign push = i_xfer_done && cnt_ff < 3'h4;
    assign st = dp_ff && ad_ff == UTS_OFF_STATUS;
    always_ff @(posedge i_clk)
    begin
        dp_ff <= acc && !i_hwrite;
        wr_ff <= acc && i_hwrite;
        ad_ff <= i_haddr;
        cnt_ff <= i_sys_rst ? 3'h0 : cnt_ff + {2'h0, push} - {2'h0, pop};
        if (i_sys_rst || push)
            hv_ff <= !i_sys_rst && cnt_ff == 3'h0;
        if (push && cnt_ff == 3'h0)
            hd_ff <= {i_xfer_endpoint, i_xfer_tx, i_xfer_odd_bank};
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_one;
        st && hv_ff && cnt_ff == 3'h1 && $past(cnt_ff, 2) == 3'h1
        && $past(cnt_ff) == 3'h1;
    endsequence
    property p_endp; s_one |-> o_hrdata[7:4] == hd_ff[5:2]; endproperty
    property p_dir; s_one |-> o_hrdata[3] == hd_ff[1]; endproperty
    property p_bank; s_one |-> o_hrdata[2] == hd_ff[0]; endproperty
    property p_hi; st |-> o_hrdata[31:8] == 24'h0; endproperty
    property p_lo; st |-> o_hrdata[1:0] == 2'h0; endproperty
    property p_lvl;
        dp_ff && ad_ff == UTS_OFF_LEVEL |-> o_hrdata == {29'h0, cnt_ff};
    endproperty
    property p_flg;
        dp_ff && ad_ff == UTS_OFF_IRQ_FLAG |-> o_hrdata[0] == (cnt_ff != 0);
    endproperty
    a_endp: assert property (p_endp) else $error("endpoint wrong");
    a_dir: assert property (p_dir) else $error("direction wrong");
    a_bank: assert property (p_bank) else $error("bank wrong");
    a_hi: assert property (p_hi) else $error("high bits set");
    a_lo: assert property (p_lo) else $error("low bits set");
    a_lvl: assert property (p_lvl) else $error("depth wrong");
    a_flg: assert property (p_flg) else $error("flag wrong");
    c_full: cover property (cnt_ff == 3'h4);
    c_pop: cover property (pop && cnt_ff == 3'h2);
    c_st: cover property (s_one);
endmodule

/* tb/uts_status_fifo_tb.sv */
// Testbench: AHB-Lite master, engine model, row loop, then edge cases.
// Assumes the slave answers with zero wait states.
`timescale 1ns/1ns
module uts_status_fifo_tb;
    import uts_pkg::*;
    logic        i_clk, i_sys_rst, i_hsel, i_hwrite, o_hreadyout, o_hresp;
    logic        o_irq, i_xfer_done, i_xfer_tx, i_xfer_odd_bank;
    logic [7:0]  i_haddr;
    logic [1:0]  i_htrans;
    logic [3:0]  i_xfer_endpoint;
    logic [31:0] i_hwdata, o_hrdata, d;
    logic [5:0]  ri [4] = '{6'h3F, 6'h00, 6'h2A, 6'h15};
    logic [31:0] ro [4] = '{32'hFC, 32'h00, 32'hA8, 32'h54};
    int          n_mismatch = 0;
    int          num_checks = 0;
    uts_status_fifo uts_status_fifo_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_xfer_done(i_xfer_done), .i_xfer_endpoint(i_xfer_endpoint),
        .i_xfer_tx(i_xfer_tx), .i_xfer_odd_bank(i_xfer_odd_bank),
        .o_irq(o_irq));
    uts_xfer_engine uts_xfer_engine_inst (.i_clk(i_clk),
        .o_done(i_xfer_done), .o_endpoint(i_xfer_endpoint),
        .o_tx(i_xfer_tx), .o_odd_bank(i_xfer_odd_bank));
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic hw;
        int n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_hreadyout !== 1'b1 && n < 20);
        if (o_hreadyout !== 1'b1)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge i_clk);
        i_haddr <= a;
        i_hwrite <= w;
        i_htrans <= UTS_HTRANS_NSEQ;
        hw;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        hw;
        d = o_hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        ck(d, e);
    endtask
    initial
    begin
        {i_sys_rst, i_hsel, i_hwrite, i_haddr, i_htrans, i_hwdata} = 45'h0;
        i_sys_rst = 1'b1;
        i_hsel = 1'b1;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rc(UTS_OFF_IRQ_FLAG, 32'h0);
        rc(UTS_OFF_IRQ_MASK, 32'h0);
        ck(o_irq, 32'h0);
        ck(o_hresp, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            uts_xfer_engine_inst.fire(ri[i], i);
            rc(UTS_OFF_IRQ_FLAG, 32'h1);
            rc(UTS_OFF_STATUS, ro[i]);
            bus(1'b1, UTS_OFF_IRQ_FLAG, 32'h1);
            rc(UTS_OFF_LEVEL, 32'h0);
        end
        $display("row test done");
        bus(1'b1, UTS_OFF_IRQ_MASK, 32'h3);
        for (int i = 0; i < 5; i++)
            uts_xfer_engine_inst.fire(ri[i % 4], 0);
        rc(UTS_OFF_LEVEL, 32'h4);
        rc(UTS_OFF_IRQ_FLAG, 32'h3);
        ck(o_irq, 32'h1);
        rc(UTS_OFF_STATUS, ro[0]);
        bus(1'b1, UTS_OFF_IRQ_FLAG, 32'h3);
        rc(UTS_OFF_IRQ_FLAG, 32'h1);
        rc(UTS_OFF_STATUS, ro[1]);
        bus(1'b1, UTS_OFF_STATUS, 32'hFFFFFFFF);
        rc(UTS_OFF_STATUS, ro[1]);
        rc(8'h10, 32'h0);
        bus(1'b1, UTS_OFF_IRQ_MASK, 32'h0);
        rc(UTS_OFF_LEVEL, 32'h3);
        ck(o_irq, 32'h0);
        bus(1'b1, UTS_OFF_IRQ_MASK, 32'h1);
        rc(UTS_OFF_IRQ_MASK, 32'h1);
        ck(o_irq, 32'h1);
        $display("full test done");
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rc(UTS_OFF_LEVEL, 32'h0);
        rc(UTS_OFF_IRQ_FLAG, 32'h0);
        rc(UTS_OFF_IRQ_MASK, 32'h0);
        ck(o_irq, 32'h0);
        $display("second reset test done");
        tally_and_finish;
    end
endmodule
bind uts_status_fifo uts_status_fifo_chk uts_status_fifo_chk_inst (.*);
